// ---- rtl/prtp_pkg.sv ----
// Package with register map, field layout and timing constants of the block.
package prtp_pkg;

	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam logic [5:0]  ADDR_GENERAL_CONTROL = 6'h1f;
	localparam logic [5:0]  ADDR_TEST_PATTERN    = 6'h25;
	localparam logic [15:0] RST_GENERAL_CONTROL  = 16'h0000;
	localparam logic [15:0] RST_TEST_PATTERN     = 16'h0480;
	localparam logic [15:0] MASK_TEST_PATTERN    = 16'h0fff;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int BIT_FULL_RESET   = 15;
	localparam int BIT_RESTART      = 14;
	localparam int POS_PULSE_HI     = 11;
	localparam int POS_PULSE_LO     = 10;
	localparam int BIT_RUN_MSB      = 9;
	localparam int BIT_FE_ENABLE    = 8;
	localparam int BIT_CH_ALL       = 7;
	localparam int POS_CH_HI        = 6;
	localparam int POS_CH_LO        = 5;
	localparam int BIT_TENB_ENABLE  = 4;
	localparam int POS_PATTERN_HI   = 3;

	// ********************************************************************
	// Timing
	// ********************************************************************
	localparam int CLK_PERIOD_NS    = 8;
	localparam int RESET_HOLD_NS    = 80;
	localparam int RESET_HOLD_CYC   =
		(RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Pulse levels coded as signed three-bit amplitude.
	localparam logic [2:0]  LEVEL_PLUS_TWO  = 3'h2;
	localparam logic [2:0]  LEVEL_MINUS_TWO = 3'h6;
	localparam logic [2:0]  LEVEL_PLUS_ONE  = 3'h1;
	localparam logic [2:0]  LEVEL_MINUS_ONE = 3'h7;

	typedef enum logic [2:0] {
		PRTP_IDLE    = 3'h1,
		PRTP_RESET   = 3'h2,
		PRTP_RESTART = 3'h4
	} prtp_state_t;

endpackage : prtp_pkg

// ---- rtl/prtp_ctrl.sv ----
// PHY reset control and transmit test-pattern control logic.
`timescale 1ns/1ps
// Contract
// - A full reset request resets the PHY and every register to default, except the strap fields.
// - A full reset reloads strap fields with the last latched straps.
// - A restart request restarts the PHY and keeps every register.
// - Pulse select 00 gives +2, 01 gives -2, 10 gives +1 and 11 gives -1.
// - The fast pattern sends a one then N zeros, N from 1 to 31.
// - A zero run length of zero clears the pattern shift register.
// - With the channel top bit set, the pattern drives all four channels.
// - With it clear, only the channel coded by the low two bits is driven.
// - 10BASE-T test modes are enabled only while bit four is set.
// - Codes 0000 to 0111 select the first eight 10BASE-T patterns.
// - Codes 1000 to 1101 select 1001, random data and four idle codes.
module prtp_ctrl #(
	parameter int RESET_CYCLES = prtp_pkg::RESET_HOLD_CYC
) (
	input  wire logic        clk_sys_i,
	input  wire logic        srst_i,
	input  wire logic [5:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [2:0]  strap_channel_i,
	output logic      [15:0] reg_rdata_o,
	output logic             phy_reset_o,
	output logic             phy_restart_o,
	output logic      [3:0]  channel_enable_o,
	output logic             tenb_test_enable_o,
	output logic      [3:0]  tenb_pattern_o,
	output logic             fast_pattern_bit_o,
	output logic             fast_pattern_active_o,
	output logic      [2:0]  pulse_level_o
);

	// ********************************************************************
	// Strap capture
	// ********************************************************************
	// Straps come from pins, so three stages; a value counts once the last
	// two agree. The first stage feeds only the second.
	logic [2:0] strap_s1;
	logic [2:0] strap_s2;
	logic [2:0] strap_s3;
	logic [2:0] strap_latched;

	always_ff @(posedge clk_sys_i) begin
		strap_s1 <= strap_channel_i;
		strap_s2 <= strap_s1;
		strap_s3 <= strap_s2;
	end

	// Set from the hardware reset until its hold time ends.
	logic       hw_boot;

	// Straps are latched only while the hardware reset sequence runs, so a
	// software reset restores what the pins showed at power-up and ignores
	// any later change on them.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			strap_latched <= prtp_pkg::RST_TEST_PATTERN[7:5];
		end else if (hw_boot && strap_s2 == strap_s3) begin
			strap_latched <= strap_s3;
		end
	end

	// ********************************************************************
	// Reset and restart sequencer
	// ********************************************************************
	prtp_pkg::prtp_state_t state;
	logic [7:0]            hold_cnt;
	logic                  wr_gen;
	logic                  wr_test;
	logic                  req_full_reset;
	logic                  req_restart;
	logic                  seq_done;

	assign wr_gen  = reg_wr_i && reg_addr_i == prtp_pkg::ADDR_GENERAL_CONTROL;
	assign wr_test = reg_wr_i && reg_addr_i == prtp_pkg::ADDR_TEST_PATTERN;

	// A write with both request bits set runs the full reset only, since a
	// full reset already restarts everything a restart would.
	assign req_full_reset = wr_gen && reg_wdata_i[prtp_pkg::BIT_FULL_RESET];
	assign req_restart    = wr_gen && reg_wdata_i[prtp_pkg::BIT_RESTART];

	// The hold counter is eight bits wide, so RESET_CYCLES must stay within
	// 1 to 256; the hold time is traded for a small counter.
	assign seq_done = hold_cnt == 8'(RESET_CYCLES - 1);

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state    <= prtp_pkg::PRTP_RESET;
			hold_cnt <= 8'h00;
			hw_boot  <= 1'b1;
		end else begin
			unique case (state)
				prtp_pkg::PRTP_IDLE: begin
					hold_cnt <= 8'h00;
					if (req_full_reset) begin
						state <= prtp_pkg::PRTP_RESET;
					end else if (req_restart) begin
						state <= prtp_pkg::PRTP_RESTART;
					end
				end
				prtp_pkg::PRTP_RESET, prtp_pkg::PRTP_RESTART: begin
					if (seq_done) begin
						state   <= prtp_pkg::PRTP_IDLE;
						hw_boot <= 1'b0;
					end else begin
						hold_cnt <= hold_cnt + 8'h01;
					end
				end
				default: begin
					state <= prtp_pkg::PRTP_RESET;
				end
			endcase
		end
	end

	// ********************************************************************
	// Sequence status outputs
	// ********************************************************************
	// Both outputs lag the state by one cycle so that they leave a flip-flop;
	// the register view reads the state itself.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			phy_reset_o   <= 1'b1;
			phy_restart_o <= 1'b0;
		end else begin
			phy_reset_o   <= state == prtp_pkg::PRTP_RESET;
			phy_restart_o <= state == prtp_pkg::PRTP_RESTART;
		end
	end

	// ********************************************************************
	// Test pattern register
	// ********************************************************************
	logic [15:0] test_pattern_control;
	logic        full_reset_request_active;

	assign full_reset_request_active = state == prtp_pkg::PRTP_RESET && !hw_boot;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			test_pattern_control <= prtp_pkg::RST_TEST_PATTERN;
		end else if (state == prtp_pkg::PRTP_RESET) begin
			// A write that lands during a full reset is lost; software waits
			// for the request bit to read zero before writing again.
			test_pattern_control <= prtp_pkg::RST_TEST_PATTERN;
			if (full_reset_request_active) begin
				test_pattern_control[7:5] <= strap_latched;
			end
		end else if (wr_test) begin
			// Restart leaves this register alone.
			test_pattern_control <= reg_wdata_i & prtp_pkg::MASK_TEST_PATTERN;
		end
	end

	// ********************************************************************
	// General control view
	// ********************************************************************
	// Only the two request bits exist; they read as one while their action
	// runs and drop to zero by themselves when it ends.
	logic [15:0] general_control;

	always_comb begin
		general_control = prtp_pkg::RST_GENERAL_CONTROL;
		general_control[prtp_pkg::BIT_FULL_RESET] =
			state == prtp_pkg::PRTP_RESET;
		general_control[prtp_pkg::BIT_RESTART] =
			state == prtp_pkg::PRTP_RESTART;
	end

	// ********************************************************************
	// Register read port
	// ********************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				prtp_pkg::ADDR_GENERAL_CONTROL: begin
					reg_rdata_o <= general_control;
				end
				prtp_pkg::ADDR_TEST_PATTERN: begin
					reg_rdata_o <= test_pattern_control;
				end
				default: begin
					reg_rdata_o <= 16'h0000;
				end
			endcase
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end

	// ********************************************************************
	// Pattern decode
	// ********************************************************************
	logic [1:0] pulse_sel;
	logic [4:0] run_len;
	logic       fe_en;
	logic       tenb_en;

	assign pulse_sel = test_pattern_control[prtp_pkg::POS_PULSE_HI:
		prtp_pkg::POS_PULSE_LO];
	assign run_len = {test_pattern_control[prtp_pkg::BIT_RUN_MSB],
		test_pattern_control[prtp_pkg::POS_PATTERN_HI:0]};
	assign fe_en   = test_pattern_control[prtp_pkg::BIT_FE_ENABLE];
	assign tenb_en = test_pattern_control[prtp_pkg::BIT_TENB_ENABLE];

	// ********************************************************************
	// Test activity qualifiers
	// ********************************************************************
	// Codes above the last listed one have no pattern, so the channels stay
	// quiet rather than send something undefined.
	localparam logic [3:0] LAST_TENB_CODE = 4'hd;

	logic tenb_ok;

	// The fast pattern takes priority, so software that leaves the 10BASE-T
	// enable set beside it still gets a clean fast pattern.
	assign tenb_ok = tenb_en && !fe_en && run_len[3:0] <= LAST_TENB_CODE;

	// The reset value matches the register's default code, so the level
	// does not step when the first decode after reset takes over.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pulse_level_o <= prtp_pkg::LEVEL_MINUS_TWO;
		end else begin
			unique case (pulse_sel)
				2'h0: pulse_level_o <= prtp_pkg::LEVEL_PLUS_TWO;
				2'h1: pulse_level_o <= prtp_pkg::LEVEL_MINUS_TWO;
				2'h2: pulse_level_o <= prtp_pkg::LEVEL_PLUS_ONE;
				2'h3: pulse_level_o <= prtp_pkg::LEVEL_MINUS_ONE;
			endcase
		end
	end

	// Codes 0000 to 1101 pass through to the 10BASE-T pattern generator in
	// their listed order; 1110 and 1111 are undefined and send nothing.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			tenb_test_enable_o <= 1'b0;
			tenb_pattern_o     <= 4'h0;
		end else begin
			tenb_test_enable_o <= tenb_ok;
			tenb_pattern_o     <= run_len[3:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			channel_enable_o <= 4'h0;
		end else if (!(tenb_ok || fe_en)) begin
			// No active test leaves every channel quiet.
			channel_enable_o <= 4'h0;
		end else if (test_pattern_control[prtp_pkg::BIT_CH_ALL]) begin
			channel_enable_o <= 4'hf;
		end else begin
			channel_enable_o <= 4'h1 << test_pattern_control[
				prtp_pkg::POS_CH_HI:prtp_pkg::POS_CH_LO];
		end
	end

	// ********************************************************************
	// Fast Ethernet one-then-zeros generator
	// ********************************************************************
	// A down-counter stands in for the shift register: a one, then run_len
	// zeros. Software clears the mode before changing the length.
	logic [4:0] zero_cnt;
	logic       fast_load;

	// The length is read live on every reload, so a nonzero length changed without
	// the clearing write first takes hold at the next reload; the period in progress keeps the old length.
	assign fast_load = zero_cnt == 5'h00;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			zero_cnt              <= 5'h00;
			fast_pattern_bit_o    <= 1'b0;
			fast_pattern_active_o <= 1'b0;
		end else if (!fe_en || run_len == 5'h00) begin
			zero_cnt              <= 5'h00;
			fast_pattern_bit_o    <= 1'b0;
			fast_pattern_active_o <= 1'b0;
		end else begin
			fast_pattern_active_o <= 1'b1;
			if (fast_load) begin
				fast_pattern_bit_o <= 1'b1;
				zero_cnt           <= run_len;
			end else begin
				fast_pattern_bit_o <= 1'b0;
				zero_cnt           <= zero_cnt - 5'h01;
			end
		end
	end

endmodule : prtp_ctrl

// ---- dv/prtp_ctrl_monitor.sv ----
// Port checker of the reset and test-pattern control block.
`timescale 1ns/1ps
module prtp_ctrl_monitor #(
	parameter int RESET_CYCLES = 10
) (
	input wire logic        clk_sys_i,
	input wire logic        srst_i,
	input wire logic [5:0]  reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        phy_reset_o,
	input wire logic        phy_restart_o,
	input wire logic [3:0]  channel_enable_o,
	input wire logic        tenb_test_enable_o,
	input wire logic [3:0]  tenb_pattern_o,
	input wire logic        fast_pattern_bit_o,
	input wire logic        fast_pattern_active_o,
	input wire logic [2:0]  pulse_level_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	logic [7:0] hold_cnt;
	logic       wr_pat;
	logic       wr_gen;
	assign wr_pat = reg_wr_i && reg_addr_i == prtp_pkg::ADDR_TEST_PATTERN
		&& !phy_reset_o;
	assign wr_gen = reg_wr_i && reg_addr_i == prtp_pkg::ADDR_GENERAL_CONTROL
		&& !phy_reset_o && !phy_restart_o;
	// A reset that never ends would hide every later check, so bound it.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !phy_reset_o)
			hold_cnt <= 8'h00;
		else
			hold_cnt <= hold_cnt + 8'h01;
	end
	function automatic logic [2:0] lvl(input logic [1:0] c);
		case (c)
			2'h0: lvl = prtp_pkg::LEVEL_PLUS_TWO;
			2'h1: lvl = prtp_pkg::LEVEL_MINUS_TWO;
			2'h2: lvl = prtp_pkg::LEVEL_PLUS_ONE;
			default: lvl = prtp_pkg::LEVEL_MINUS_ONE;
		endcase
	endfunction : lvl
	chk_reset_starts: assert property (
		wr_gen && reg_wdata_i[15] |-> ##[1:3] phy_reset_o)
		else $error("full reset did not start");
	chk_restart_starts: assert property (
		wr_gen && reg_wdata_i[14] && !reg_wdata_i[15] |-> ##[1:3] phy_restart_o)
		else $error("restart did not start");
	chk_reset_bounded: assert property (
		hold_cnt <= RESET_CYCLES + 2)
		else $error("reset held too long");
	chk_pulse_map: assert property (
		wr_pat |-> ##2 pulse_level_o == lvl($past(reg_wdata_i[11:10], 2)))
		else $error("pulse level wrong");
	chk_code_follow: assert property (
		wr_pat |-> ##2 tenb_pattern_o == $past(reg_wdata_i[3:0], 2))
		else $error("pattern code wrong");
	chk_channel_route: assert property (
		wr_pat && reg_wdata_i[4] && !reg_wdata_i[8] && reg_wdata_i[3:0] <= 4'hd
		|-> ##2 tenb_test_enable_o &&
		channel_enable_o == ($past(reg_wdata_i[7], 2)
		? 4'hf : 4'h1 << $past(reg_wdata_i[6:5], 2)))
		else $error("channel routing wrong");
	chk_tenb_off: assert property (
		wr_pat && !reg_wdata_i[8] && (!reg_wdata_i[4] || reg_wdata_i[3:0] > 4'hd)
		|-> ##2 !tenb_test_enable_o && channel_enable_o == 4'h0)
		else $error("test output not off");
	chk_zero_length: assert property (
		wr_pat && reg_wdata_i[8] && {reg_wdata_i[9], reg_wdata_i[3:0]} == 5'h00
		|-> ##2 !fast_pattern_active_o && !fast_pattern_bit_o)
		else $error("zero length not cleared");
	chk_fast_start: assert property (
		wr_pat && reg_wdata_i[8] && {reg_wdata_i[9], reg_wdata_i[3:0]} != 5'h00
		|-> ##2 fast_pattern_bit_o && fast_pattern_active_o)
		else $error("fast pattern did not start");
	cover property ($rose(phy_reset_o));
	cover property ($rose(phy_restart_o));
	cover property (fast_pattern_active_o && fast_pattern_bit_o);
endmodule : prtp_ctrl_monitor
bind prtp_ctrl prtp_ctrl_monitor #(.RESET_CYCLES(RESET_CYCLES)) u_monitor (
	.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .phy_reset_o(phy_reset_o),
	.phy_restart_o(phy_restart_o), .channel_enable_o(channel_enable_o),
	.tenb_test_enable_o(tenb_test_enable_o), .tenb_pattern_o(tenb_pattern_o),
	.fast_pattern_bit_o(fast_pattern_bit_o), .pulse_level_o(pulse_level_o),
	.fast_pattern_active_o(fast_pattern_active_o));

// ---- dv/prtp_line_model.sv ----
// Far-end receiver model that measures the zero runs on the test line.
`timescale 1ns/1ps
module prtp_line_model (
	input  wire logic       clk_sys_i,
	input  wire logic       line_i,
	output logic      [7:0] run_o
);
	logic [7:0] zeros;
	// A run is only known once the next one closes it.
	always_ff @(posedge clk_sys_i) begin
		if (line_i) begin
			run_o <= zeros;
			zeros <= 8'h00;
		end else begin
			zeros <= zeros + 8'h01;
		end
	end
endmodule : prtp_line_model

// ---- dv/testbench.sv ----
// Self-checking testbench of the reset and test-pattern control block.
`timescale 1ns/1ps
module testbench;
	logic        clk_sys_i = 1'b0;
	logic        srst_i    = 1'b1;
	logic [5:0]  reg_addr_i = 6'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic        reg_wr_i  = 1'b0;
	logic        reg_rd_i  = 1'b0;
	logic [2:0]  strap_i   = 3'h2;
	logic [15:0] rdata;
	logic        rst;
	logic        rsr;
	logic [3:0]  chan;
	logic        ten;
	logic [3:0]  code;
	logic        fbit;
	logic        fact;
	logic [2:0]  lvl;
	logic [7:0]  run_len;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          cycles    = 0;
	always #4 clk_sys_i = ~clk_sys_i;
	prtp_ctrl #(.RESET_CYCLES(2)) u_prtp_ctrl (.clk_sys_i(clk_sys_i),
		.srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .strap_channel_i(strap_i),
		.reg_rdata_o(rdata), .phy_reset_o(rst), .phy_restart_o(rsr),
		.channel_enable_o(chan), .tenb_test_enable_o(ten),
		.tenb_pattern_o(code), .fast_pattern_bit_o(fbit),
		.fast_pattern_active_o(fact), .pulse_level_o(lvl));
	prtp_line_model u_prtp_line_model (.clk_sys_i(clk_sys_i), .line_i(fbit),
		.run_o(run_len));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic settle;
		@(posedge clk_sys_i);
		#1;
	endtask : settle
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 chk("read", e, rdata);
	endtask : rdchk
	// Waits for a reset or restart level to drop, with a ceiling.
	task automatic wait_idle;
		for (int i = 0; i < 40 && (rst !== 1'b0 || rsr !== 1'b0); i++)
			settle();
		chk("sequence end", 16'h0000, {14'h0, rst, rsr});
	endtask : wait_idle
	task automatic t_regmap;
		rdchk(prtp_pkg::ADDR_GENERAL_CONTROL, 16'h0000);
		rdchk(prtp_pkg::ADDR_TEST_PATTERN, prtp_pkg::RST_TEST_PATTERN);
		wr(prtp_pkg::ADDR_TEST_PATTERN, 16'hffef);
		wr(prtp_pkg::ADDR_GENERAL_CONTROL, 16'h3fff);
		rdchk(6'h00, 16'h0000);
		rdchk(prtp_pkg::ADDR_TEST_PATTERN, 16'h0fef);
		rdchk(prtp_pkg::ADDR_GENERAL_CONTROL, 16'h0000);
	endtask : t_regmap
	task automatic t_patterns;
		logic [2:0] lv[4];
		logic [3:0] c;
		logic       en;
		lv = '{prtp_pkg::LEVEL_PLUS_TWO, prtp_pkg::LEVEL_MINUS_TWO,
			prtp_pkg::LEVEL_PLUS_ONE, prtp_pkg::LEVEL_MINUS_ONE};
		for (int p = 0; p < 16; p++) begin
			c = p[3:0];
			en = c <= 4'hd;
			wr(prtp_pkg::ADDR_TEST_PATTERN, {4'h0, c[1:0], 2'h0, c[2:0], 1'b1, c});
			settle();
			chk("enable", {15'h0, en}, {15'h0, ten});
			chk("code", {12'h0, c}, {12'h0, code});
			chk("level", {13'h0, lv[c[1:0]]}, {13'h0, lvl});
			chk("channels", {12'h0, !en ? 4'h0 : c[2] ? 4'hf : 4'h1 << c[1:0]},
				{12'h0, chan});
		end
	endtask : t_patterns
	task automatic t_fast;
		logic [4:0] lens[3];
		lens = '{5'h01, 5'h1f, 5'h00};
		wr(6'h00, 16'h2000);
		rdchk(6'h00, 16'h0000);
		foreach (lens[k]) begin
			wr(prtp_pkg::ADDR_TEST_PATTERN, 16'h0000);
			wr(prtp_pkg::ADDR_TEST_PATTERN,
				{6'h00, lens[k][4], 5'h10, lens[k][3:0]});
			repeat (3 * lens[k] + 8) settle();
			chk("active", {15'h0, lens[k] != 5'h00}, {15'h0, fact});
			if (lens[k] != 5'h00)
				chk("zero run", {11'h0, lens[k]}, {8'h0, run_len});
			else
				chk("line", 16'h0000, {15'h0, fbit});
		end
	endtask : t_fast
	task automatic t_reset;
		// A pin change after power-up must not reach the reloaded register.
		strap_i <= 3'h5;
		wr(prtp_pkg::ADDR_TEST_PATTERN, 16'h0c1f);
		wr(prtp_pkg::ADDR_GENERAL_CONTROL, 16'h8000);
		settle();
		chk("reset", 16'h0001, {15'h0, rst});
		wait_idle();
		rdchk(prtp_pkg::ADDR_GENERAL_CONTROL, 16'h0000);
		rdchk(prtp_pkg::ADDR_TEST_PATTERN, 16'h0440);
	endtask : t_reset
	task automatic t_restart;
		wr(prtp_pkg::ADDR_TEST_PATTERN, 16'h0812);
		wr(prtp_pkg::ADDR_GENERAL_CONTROL, 16'h4000);
		settle();
		chk("restart", 16'h0001, {15'h0, rsr});
		wait_idle();
		rdchk(prtp_pkg::ADDR_GENERAL_CONTROL, 16'h0000);
		rdchk(prtp_pkg::ADDR_TEST_PATTERN, 16'h0812);
	endtask : t_restart
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			wrap_up();
		end
	end
	initial begin
		repeat (16) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		settle();
		wait_idle();
		t_regmap();
		t_patterns();
		t_fast();
		t_reset();
		t_restart();
		wrap_up();
	end
endmodule : testbench
